// File: design/odc_pkg.sv
// Package with shared constants and types of the octal converter command control.
package odc_pkg;
  localparam int WORD_BITS = 16;
  localparam int NUM_CH = 8;
  localparam int DATA_BITS = 12;
  localparam int BIT_CTRL = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 12;
  localparam int DATA_HI = 11;
  localparam int DATA_LO = 0;
  localparam int FULL_RESET_BIT = 12;
  localparam int SYNC_STAGES = 2;
  localparam logic [4:0] LAST_BIT_COUNT = 5'h10;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  localparam logic [2:0] CMD_REF_GAIN = 3'h4;
  localparam logic [2:0] CMD_LOAD_MODE = 3'h5;
  localparam logic [2:0] CMD_POWER_DOWN = 3'h6;
  localparam logic [2:0] CMD_RESET = 3'h7;
  localparam logic [DATA_BITS-1:0] DATA_RESET = 12'h000;
  localparam logic [NUM_CH-1:0] PD_RESET = 8'h00;

  typedef enum logic [1:0] {
    ODC_LOAD_LOW = 2'h0,
    ODC_LOAD_HIGH = 2'h1,
    ODC_LOAD_SINGLE = 2'h2,
    ODC_LOAD_RSVD = 2'h3
  } odc_load_mode_t;

  typedef struct packed {
    logic gain;
    logic buffered;
    logic supply_ref;
  } odc_group_cfg_t;

  typedef struct packed {
    odc_group_cfg_t upper_group;
    odc_group_cfg_t lower_group;
  } odc_ref_cfg_t;

  localparam odc_ref_cfg_t REF_RESET = 6'h00;
endpackage : odc_pkg

// File: design/odc_sync.sv
// Two flip-flop synchroniser for a single level.
`timescale 1ns/10ps
module odc_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic d,
  output logic q
);
  logic stage1;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage1 <= 1'b0;
      q <= 1'b0;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule : odc_sync

// File: design/odc_shift.sv
// Serial front end on the link clock: shifts frames and toggles on each complete one.
`timescale 1ns/10ps
module odc_shift (
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic sdata,
  output logic [15:0] word,
  output logic done_toggle
);
  // The link side has no reset of its own, so its flops start at zero.
  logic [4:0] count = 5'h00;
  logic [15:0] shreg = 16'h0000;
  logic [15:0] word_q = 16'h0000;
  logic toggle_q = 1'b0;

  // The frame signal resets the counter asynchronously, so an aborted frame is forgotten.
  always_ff @(negedge sclk or posedge frame_n) begin
    if (frame_n) begin
      count <= 5'h00;
    end else if (count != odc_pkg::LAST_BIT_COUNT) begin
      count <= count + 5'h01;
    end
  end

  always_ff @(negedge sclk) begin
    if (!frame_n && count != odc_pkg::LAST_BIT_COUNT) begin
      shreg <= {shreg[14:0], sdata};
    end
  end

  // The word is published and the toggle flips on the sixteenth falling edge.
  always_ff @(negedge sclk) begin
    if (!frame_n && count == 5'h0F) begin
      word_q <= {shreg[14:0], sdata};
      toggle_q <= ~toggle_q;
    end
  end

  assign word = word_q;
  assign done_toggle = toggle_q;
endmodule : odc_shift

// File: design/odc_ctrl.sv
// Command decoding, double-buffered data and load control of the octal converter.
// Summary of operation
// - Shift sixteen bits MSB first on falling edges.
// - Early frame end discards the frame.
// - Top bit zero writes addressed channel data.
// - Power-on clears data, defaults all settings.
// - Code 100 loads both groups reference settings.
// - Bits 2 and 3 select buffering.
// - Bits 4 and 5 select double gain.
// - Bits 0 and 1 select supply reference.
// - Supply reference forces unbuffered unity gain.
// - Code 101 sets load mode from bits.
// - Latched load mode is the default.
// - Single update code gives one load pulse.
// - Code 110 powers down channels with ones.
// - Code 111 bit12 zero clears data.
// - Bit12 one also resets all controls.
// - Front end active only while frame low.
// - Completed write goes to input register.
// - Outputs transparent in mode 00 or pin low.
// - Synchronous load updates after sixteenth edge.
// - Falling load pin copies inputs to outputs.
// - Reference settings are double buffered too.
// - Only written channels update on load.
`timescale 1ns/10ps
module odc_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic sdata,
  input wire logic load_outputs_n,
  output logic [odc_pkg::NUM_CH*odc_pkg::DATA_BITS-1:0] out_data,
  output odc_pkg::odc_ref_cfg_t out_ref,
  output logic [odc_pkg::NUM_CH-1:0] power_down,
  output odc_pkg::odc_load_mode_t load_mode,
  output logic [odc_pkg::NUM_CH-1:0] pending
);
  logic [15:0] link_word;
  logic link_toggle;
  logic toggle_sync;
  logic toggle_seen;
  logic load_sync;
  logic load_prev;
  logic frame_done;
  logic pin_fall;
  logic load_now;
  logic single_pulse;
  logic [2:0] cmd;
  logic [odc_pkg::DATA_BITS-1:0] in_data [odc_pkg::NUM_CH];
  odc_pkg::odc_ref_cfg_t in_ref;
  logic ref_pending;
  logic data_clear;
  logic full_reset;
  logic [odc_pkg::NUM_CH-1:0] write_hit;
  logic [1:0] settle;
  logic settled;

  // Masks gain and buffering of a group when the supply serves as reference.
  function automatic odc_pkg::odc_group_cfg_t effective(input odc_pkg::odc_group_cfg_t g);
    odc_pkg::odc_group_cfg_t r;
    r = g;
    if (g.supply_ref) begin
      r.gain = 1'b0;
      r.buffered = 1'b0;
    end
    return r;
  endfunction : effective

  odc_shift u_shift (
    .sclk(sclk),
    .frame_n(frame_n),
    .sdata(sdata),
    .word(link_word),
    .done_toggle(link_toggle)
  );

  odc_sync u_sync_done (
    .clk(clk),
    .reset_n(reset_n),
    .d(link_toggle),
    .q(toggle_sync)
  );

  odc_sync u_sync_load (
    .clk(clk),
    .reset_n(reset_n),
    .d(load_outputs_n),
    .q(load_sync)
  );

  // Crossings are ignored for a few cycles after reset, so that a toggle left over from
  // before the reset is not taken as a new frame and a pin still settling is no edge.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      settle <= 2'h0;
    end else if (settle != odc_pkg::SETTLE_CYCLES) begin
      settle <= settle + 2'h1;
    end
  end

  assign settled = settle == odc_pkg::SETTLE_CYCLES;

  // The word is stable for many system clocks after the toggle crosses.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      toggle_seen <= 1'b0;
      load_prev <= 1'b1;
    end else begin
      toggle_seen <= toggle_sync;
      load_prev <= load_sync;
    end
  end

  assign frame_done = settled && (toggle_sync ^ toggle_seen);
  assign cmd = link_word[odc_pkg::BIT_CTRL -: 3];
  assign pin_fall = settled && load_prev && !load_sync;
  assign data_clear = frame_done && cmd == odc_pkg::CMD_RESET;
  assign full_reset = data_clear && link_word[odc_pkg::FULL_RESET_BIT];
  // Mode 00 or a low pin keeps outputs following inputs; single update adds one pulse.
  assign load_now = load_mode == odc_pkg::ODC_LOAD_LOW || (settled && !load_sync)
                    || pin_fall || single_pulse;

  generate
    for (genvar ch = 0; ch < odc_pkg::NUM_CH; ch++) begin : g_ch
      assign write_hit[ch] = frame_done && !link_word[odc_pkg::BIT_CTRL]
                             && link_word[odc_pkg::ADDR_HI:odc_pkg::ADDR_LO] == 3'(ch);

      always_ff @(posedge clk) begin
        if (!reset_n || data_clear) begin
          in_data[ch] <= odc_pkg::DATA_RESET;
        end else if (write_hit[ch]) begin
          in_data[ch] <= link_word[odc_pkg::DATA_HI:odc_pkg::DATA_LO];
        end
      end

      always_ff @(posedge clk) begin
        if (!reset_n || data_clear) begin
          pending[ch] <= 1'b0;
        end else if (write_hit[ch]) begin
          pending[ch] <= 1'b1;
        end else if (load_now) begin
          pending[ch] <= 1'b0;
        end
      end

      // Only channels written since their last update move on a load.
      always_ff @(posedge clk) begin
        if (!reset_n || data_clear) begin
          out_data[ch*odc_pkg::DATA_BITS +: odc_pkg::DATA_BITS] <= odc_pkg::DATA_RESET;
        end else if (load_now && pending[ch]) begin
          out_data[ch*odc_pkg::DATA_BITS +: odc_pkg::DATA_BITS] <= in_data[ch];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!reset_n || full_reset) begin
      in_ref <= odc_pkg::REF_RESET;
      ref_pending <= 1'b0;
    end else if (frame_done && cmd == odc_pkg::CMD_REF_GAIN) begin
      in_ref.lower_group.buffered <= link_word[2];
      in_ref.upper_group.buffered <= link_word[3];
      in_ref.lower_group.gain <= link_word[4];
      in_ref.upper_group.gain <= link_word[5];
      in_ref.lower_group.supply_ref <= link_word[0];
      in_ref.upper_group.supply_ref <= link_word[1];
      ref_pending <= 1'b1;
    end else if (load_now) begin
      ref_pending <= 1'b0;
    end
  end

  // Reference settings reach the outputs only through a load.
  always_ff @(posedge clk) begin
    if (!reset_n || full_reset) begin
      out_ref <= odc_pkg::REF_RESET;
    end else if (load_now && ref_pending) begin
      out_ref.lower_group <= effective(in_ref.lower_group);
      out_ref.upper_group <= effective(in_ref.upper_group);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || full_reset) begin
      load_mode <= odc_pkg::ODC_LOAD_HIGH;
      single_pulse <= 1'b0;
    end else if (frame_done && cmd == odc_pkg::CMD_LOAD_MODE) begin
      if (link_word[1:0] == 2'h2) begin
        single_pulse <= 1'b1;
      end else if (link_word[1:0] != 2'h3) begin
        load_mode <= odc_pkg::odc_load_mode_t'(link_word[1:0]);
        single_pulse <= 1'b0;
      end else begin
        single_pulse <= 1'b0;
      end
    end else begin
      single_pulse <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || full_reset) begin
      power_down <= odc_pkg::PD_RESET;
    end else if (frame_done && cmd == odc_pkg::CMD_POWER_DOWN) begin
      power_down <= link_word[7:0];
    end
  end

  a_single_pulse_once: assert property (@(posedge clk) disable iff (!reset_n)
    single_pulse |=> !single_pulse)
    else $error("Single update pulse lasted more than one cycle.");

  a_supply_forces_unity: assert property (@(posedge clk) disable iff (!reset_n)
    out_ref.lower_group.supply_ref |-> !out_ref.lower_group.gain && !out_ref.lower_group.buffered)
    else $error("Supply reference group not forced to unity unbuffered.");

  a_mode_default: assert property (@(posedge clk)
    $rose(reset_n) |-> load_mode == odc_pkg::ODC_LOAD_HIGH)
    else $error("Load mode not latched after reset.");

  a_reserved_keeps: assert property (@(posedge clk) disable iff (!reset_n)
    frame_done && cmd == odc_pkg::CMD_LOAD_MODE && link_word[1:0] == 2'h3 && !full_reset
    |=> $stable(load_mode))
    else $error("Reserved load code changed the load mode.");

  a_power_down_load: assert property (@(posedge clk) disable iff (!reset_n)
    frame_done && cmd == odc_pkg::CMD_POWER_DOWN |=> power_down == $past(link_word[7:0]))
    else $error("Power-down word not applied.");

  a_clear_data: assert property (@(posedge clk) disable iff (!reset_n)
    data_clear |=> out_data == '0 && pending == '0)
    else $error("Data clear left output data.");

  a_full_reset_ctrl: assert property (@(posedge clk) disable iff (!reset_n)
    full_reset |=> power_down == odc_pkg::PD_RESET && load_mode == odc_pkg::ODC_LOAD_HIGH)
    else $error("Control reset left settings.");

  a_latched_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !load_now && !data_clear |=> $stable(out_data))
    else $error("Outputs moved while latched.");

  a_write_pending: assert property (@(posedge clk) disable iff (!reset_n)
    write_hit[0] |=> pending[0] && in_data[0] == $past(link_word[11:0]))
    else $error("Channel write not captured.");

  a_single_pulse_set: assert property (@(posedge clk) disable iff (!reset_n)
    frame_done && cmd == odc_pkg::CMD_LOAD_MODE && link_word[1:0] == 2'h2 |=> single_pulse)
    else $error("Single update code gave no pulse.");

  a_single_keeps_mode: assert property (@(posedge clk) disable iff (!reset_n)
    frame_done && cmd == odc_pkg::CMD_LOAD_MODE && link_word[1:0] == 2'h2 |=> $stable(load_mode))
    else $error("Single update code changed the load mode.");

  a_mode_code_load: assert property (@(posedge clk) disable iff (!reset_n)
    frame_done && cmd == odc_pkg::CMD_LOAD_MODE && !link_word[1]
    |=> load_mode == $past(link_word[1:0]))
    else $error("Load mode code not stored.");

  a_mode_legal: assert property (@(posedge clk) disable iff (!reset_n)
    load_mode != odc_pkg::ODC_LOAD_SINGLE && load_mode != odc_pkg::ODC_LOAD_RSVD)
    else $error("Load mode holds a code that is never stored.");

  a_supply_upper_unity: assert property (@(posedge clk) disable iff (!reset_n)
    out_ref.upper_group.supply_ref |-> !out_ref.upper_group.gain && !out_ref.upper_group.buffered)
    else $error("Upper supply reference group not forced to unity unbuffered.");

  a_ref_held: assert property (@(posedge clk) disable iff (!reset_n)
    !load_now && !full_reset |=> $stable(out_ref))
    else $error("Reference outputs moved without a load.");

  a_ref_load: assert property (@(posedge clk) disable iff (!reset_n)
    load_now && ref_pending && !full_reset
    |=> out_ref.lower_group.supply_ref == $past(in_ref.lower_group.supply_ref)
    && out_ref.upper_group.supply_ref == $past(in_ref.upper_group.supply_ref))
    else $error("Reference settings not transferred on load.");

  a_ref_lower_capture: assert property (@(posedge clk) disable iff (!reset_n)
    frame_done && cmd == odc_pkg::CMD_REF_GAIN
    |=> in_ref.lower_group == {$past(link_word[4]), $past(link_word[2]), $past(link_word[0])})
    else $error("Lower group reference word not captured.");

  a_ref_upper_capture: assert property (@(posedge clk) disable iff (!reset_n)
    frame_done && cmd == odc_pkg::CMD_REF_GAIN
    |=> in_ref.upper_group == {$past(link_word[5]), $past(link_word[3]), $past(link_word[1])})
    else $error("Upper group reference word not captured.");

  a_ref_pending_set: assert property (@(posedge clk) disable iff (!reset_n)
    frame_done && cmd == odc_pkg::CMD_REF_GAIN |=> ref_pending)
    else $error("Reference word left nothing pending.");

  a_power_down_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !frame_done |=> $stable(power_down))
    else $error("Power-down state moved without a frame.");

  a_mode_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !frame_done |=> $stable(load_mode))
    else $error("Load mode moved without a frame.");

  a_input_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !frame_done |=> $stable(in_data[7]))
    else $error("Input register moved without a frame.");

  a_write_upper: assert property (@(posedge clk) disable iff (!reset_n)
    write_hit[7] |=> pending[7] && in_data[7] == $past(link_word[11:0]))
    else $error("Upper channel write not captured.");

  a_addr_decode: assert property (@(posedge clk) disable iff (!reset_n)
    frame_done && !link_word[odc_pkg::BIT_CTRL]
    && link_word[odc_pkg::ADDR_HI:odc_pkg::ADDR_LO] == 3'h2 |-> write_hit == 8'h04)
    else $error("Channel address decoded wrongly.");

  a_ctrl_no_write: assert property (@(posedge clk) disable iff (!reset_n)
    frame_done && link_word[odc_pkg::BIT_CTRL] |-> write_hit == '0)
    else $error("Control word wrote a channel.");

  a_pending_clear: assert property (@(posedge clk) disable iff (!reset_n)
    load_now && write_hit == '0 && !data_clear |=> pending == '0)
    else $error("Load left a channel pending.");

  a_unwritten_kept: assert property (@(posedge clk) disable iff (!reset_n)
    !pending[2] && !data_clear |=> $stable(out_data[35:24]))
    else $error("Unwritten channel output moved.");

  a_load_transfer: assert property (@(posedge clk) disable iff (!reset_n)
    load_now && pending[2] && !data_clear |=> out_data[35:24] == $past(in_data[2]))
    else $error("Pending channel not transferred on load.");

  a_low_mode_follow: assert property (@(posedge clk) disable iff (!reset_n)
    load_mode == odc_pkg::ODC_LOAD_LOW && pending[7] && !write_hit[7] && !data_clear
    |=> out_data[95:84] == $past(in_data[7]) && !pending[7])
    else $error("Output did not follow input in load-low mode.");

  a_pin_low_follow: assert property (@(posedge clk) disable iff (!reset_n)
    settled && !load_sync && pending[2] && !write_hit[2] && !data_clear
    |=> out_data[35:24] == $past(in_data[2]))
    else $error("Output did not follow input while the load pin was low.");

  a_clear_inputs: assert property (@(posedge clk) disable iff (!reset_n)
    data_clear |=> in_data[0] == odc_pkg::DATA_RESET && in_data[7] == odc_pkg::DATA_RESET)
    else $error("Data clear left input registers.");

  a_full_reset_ref: assert property (@(posedge clk) disable iff (!reset_n)
    full_reset |=> in_ref == odc_pkg::REF_RESET && out_ref == odc_pkg::REF_RESET
    && !single_pulse)
    else $error("Control reset left reference settings.");

  a_clear_keeps_ctrl: assert property (@(posedge clk) disable iff (!reset_n)
    data_clear && !full_reset |=> $stable(power_down) && $stable(load_mode) && $stable(in_ref))
    else $error("Data clear changed control settings.");

  a_power_up_state: assert property (@(posedge clk)
    $rose(reset_n) |-> out_data == '0 && pending == '0 && power_down == odc_pkg::PD_RESET
    && out_ref == odc_pkg::REF_RESET)
    else $error("State after reset not cleared.");

  a_frame_one_shot: assert property (@(posedge clk) disable iff (!reset_n)
    frame_done |=> !frame_done)
    else $error("One frame decoded twice.");
endmodule : odc_ctrl

// File: verification/odc_host.sv
// Host serial master model that frames words onto the link.
`timescale 1ns/10ps
module odc_host (
  output logic sclk,
  output logic frame_n,
  output logic sdata
);
  initial begin
    sclk = 1'b1;
    frame_n = 1'b1;
    sdata = 1'b0;
  end

  // Sends the top n bits of w; split pauses the clock between two bytes.
  task automatic send(input logic [15:0] w, input int n, input bit split);
    int i;
    frame_n = 1'b0;
    for (i = 15; i > 15 - n; i--) begin
      sdata = w[i];
      #62.5 sclk = 1'b0;
      #62.5 sclk = 1'b1;
      if (split && i == 8) begin
        #250;
      end
    end
    #62.5 frame_n = 1'b1;
    sdata = ~sdata;
    #125;
  endtask : send
endmodule : odc_host

// File: verification/tb.sv
// Self-checking testbench of the octal converter command control.
`timescale 1ns/10ps
module tb;
  logic clk, reset_n, load_n, sclk, frame_n, sdata;
  logic [95:0] out_data;
  odc_pkg::odc_ref_cfg_t out_ref;
  logic [7:0] power_down, pending;
  odc_pkg::odc_load_mode_t load_mode;
  int fails, total_checks;

  odc_host odc_host_inst (.sclk(sclk), .frame_n(frame_n), .sdata(sdata));
  odc_ctrl odc_ctrl_inst (.clk(clk), .reset_n(reset_n), .sclk(sclk), .frame_n(frame_n),
    .sdata(sdata), .load_outputs_n(load_n), .out_data(out_data), .out_ref(out_ref),
    .power_down(power_down), .load_mode(load_mode), .pending(pending));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic send(input logic [15:0] w, input int n = 16, input bit split = 1'b0);
    #1 odc_host_inst.send(w, n, split);
    repeat (4) @(posedge clk);
  endtask : send

  task automatic pin_pulse();
    @(posedge clk) #1 load_n = 1'b0;
    repeat (8) @(posedge clk);
    #1 load_n = 1'b1;
    repeat (8) @(posedge clk);
  endtask : pin_pulse

  task automatic t_reset();
    chk(out_data, 96'h0, "data");
    chk(96'(out_ref), 96'h0, "ref");
    chk(96'(power_down), 96'h0, "pd");
    chk(96'(load_mode), 96'h1, "mode");
    chk(96'(pending), 96'h0, "pend");
  endtask : t_reset

  task automatic t_write_load();
    send(16'h2123);
    chk(96'(pending), 96'h04, "pend C");
    chk(out_data, 96'h0, "held");
    send(16'h3777, 10);
    chk(96'(pending), 96'h04, "abort");
    pin_pulse();
    chk(96'(out_data[35:24]), 96'h123, "C out");
    chk(96'(out_data[47:36]), 96'h0, "D out");
    chk(96'(pending), 96'h0, "pend clr");
  endtask : t_write_load

  task automatic t_ref();
    send(16'h9FE6);
    chk(96'(out_ref), 96'h0, "ref held");
    pin_pulse();
    chk(96'(out_ref), 96'h0A, "ref sup");
    send(16'h8030);
    pin_pulse();
    chk(96'(out_ref), 96'h24, "ref gain");
  endtask : t_ref

  task automatic t_modes();
    send(16'hA003);
    chk(96'(load_mode), 96'h1, "rsvd");
    send(16'hA000);
    chk(96'(load_mode), 96'h0, "low");
    send(16'h7ABC);
    chk(96'(out_data[95:84]), 96'hABC, "H out");
    send(16'hA001);
    send(16'h0055);
    chk(96'(out_data[11:0]), 96'h0, "A held");
    chk(96'(pending), 96'h01, "pend A");
    send(16'hA002);
    chk(96'(out_data[11:0]), 96'h055, "A single");
    chk(96'(load_mode), 96'h1, "mode kept");
  endtask : t_modes

  task automatic t_power();
    send(16'hC0A5, 16, 1'b1);
    chk(96'(power_down), 96'hA5, "pd bytes");
    send(16'hC003);
    chk(96'(power_down), 96'h03, "pd up");
  endtask : t_power

  task automatic t_reset_words();
    send(16'h1456);
    send(16'hE000);
    chk(out_data, 96'h0, "clr data");
    chk(96'(pending), 96'h0, "clr pend");
    chk(96'(power_down), 96'h03, "pd kept");
    chk(96'(out_ref), 96'h24, "ref kept");
    send(16'hA000);
    send(16'hF000);
    chk(96'(power_down), 96'h0, "pd rst");
    chk(96'(out_ref), 96'h0, "ref rst");
    chk(96'(load_mode), 96'h1, "mode rst");
  endtask : t_reset_words

  task automatic tally_and_finish();
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    fails = 0;
    total_checks = 0;
    reset_n = 1'b0;
    load_n = 1'b1;
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_write_load();
    t_ref();
    t_modes();
    t_power();
    t_reset_words();
    tally_and_finish();
  end
endmodule : tb
